// ==== hw/odt_pkg.sv ====
// ==========================================================================
// shared constants and types of the on-delay count-up timer
package odt_pkg;

	// ==========================================================================
	// clock and time base
	localparam int unsigned CLK_PERIOD_NS = 40;
	localparam int unsigned MS_TIME_NS = 1000000;
	// least time, so round up to whole cycles
	localparam int unsigned MS_CYCLES = (MS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [15:0] UNIT_1S_MS = 16'h03e8;
	localparam logic [15:0] UNIT_100MS_MS = 16'h0064;
	localparam logic [15:0] UNIT_10MS_MS = 16'h000a;
	localparam logic [15:0] UNIT_1MS_MS = 16'h0001;

	// ==========================================================================
	// register map, word addresses on the plain port
	localparam int ADDR_W = 5;
	localparam int DATA_W = 16;
	localparam logic [4:0] ADDR_CTRL = 5'h00;
	localparam logic [4:0] ADDR_PRESET = 5'h01;
	localparam logic [4:0] ADDR_DREG_IDX = 5'h02;
	localparam logic [4:0] ADDR_STATUS = 5'h03;
	localparam logic [4:0] ADDR_COUNT = 5'h04;
	localparam logic [4:0] ADDR_INST = 5'h05;
	localparam logic [4:0] ADDR_REF = 5'h06;
	localparam logic [4:0] ADDR_DREG_BASE = 5'h10;
	localparam int DREG_NUM = 16;
	localparam int DREG_IDX_W = 4;

	// ==========================================================================
	// field layout and reset values
	localparam int CTRL_SRC_BIT = 0;
	localparam int CTRL_TB_LSB = 1;
	localparam int CTRL_TB_MSB = 2;
	localparam int STAT_OUT_BIT = 0;
	localparam int STAT_TRIG_BIT = 1;
	localparam int STAT_RUN_BIT = 2;
	localparam int STAT_IDX_OK_BIT = 3;
	localparam logic [15:0] ZERO16 = 16'h0000;
	localparam logic [15:0] ONE16 = 16'h0001;
	localparam logic [15:0] PRESET_DEFAULT = 16'h000a;
	localparam logic [7:0] INDEX_MAX_FULL = 8'hc7;
	localparam logic [7:0] INDEX_MAX_SMALL = 8'h63;

	// ==========================================================================
	// types
	typedef enum logic [1:0] {ODT_TB_1S, ODT_TB_100MS, ODT_TB_10MS, ODT_TB_1MS} odt_tbase_t;
	typedef enum logic [1:0] {ODT_ST_IDLE, ODT_ST_COUNT, ODT_ST_DONE} odt_state_t;

	typedef struct packed {
		logic src_dreg;
		odt_tbase_t tbase;
		logic [DREG_IDX_W-1:0] dreg_idx;
	} odt_cfg_t;

	localparam odt_cfg_t CFG_RST = '{src_dreg: 1'b0, tbase: ODT_TB_1S, dreg_idx: 4'h0};

	// length of one count step in milliseconds
	function automatic logic [15:0] unit_len_ms(input odt_tbase_t tb);
		logic [15:0] len;
		len = UNIT_1MS_MS;
		case (tb)
			ODT_TB_1S: len = UNIT_1S_MS;
			ODT_TB_100MS: len = UNIT_100MS_MS;
			ODT_TB_10MS: len = UNIT_10MS_MS;
			default: len = UNIT_1MS_MS;
		endcase
		return len;
	endfunction : unit_len_ms

endpackage : odt_pkg

// ==== hw/odt_timebase.sv ====
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// free-running reference timer and count-step tick generator
module odt_timebase #(
	parameter int unsigned MS_CYCLES = odt_pkg::MS_CYCLES
) (
	input wire logic core_clk, // system clock
	input wire logic rst_b, // async reset, active low
	input wire odt_pkg::odt_tbase_t tbase, // selected step length
	output logic unit_tick, // one-cycle pulse per step
	output logic [15:0] ref_timer // free-running millisecond count
);

	localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);

	logic [15:0] presc_r;
	logic ms_tick;
	logic [15:0] unit_cnt_r;
	odt_pkg::odt_tbase_t tbase_r;
	logic [15:0] unit_last;

	assign ms_tick = (presc_r == MS_LAST);
	assign unit_last = odt_pkg::unit_len_ms(tbase) - odt_pkg::ONE16;

	// ==========================================================================
	// millisecond prescaler, never stopped so steps stay asynchronous to the scan
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			presc_r <= odt_pkg::ZERO16;
		end else if (ms_tick) begin
			presc_r <= odt_pkg::ZERO16;
		end else begin
			presc_r <= presc_r + odt_pkg::ONE16;
		end
	end

	// 16-bit reference timer, wraps freely
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ref_timer <= odt_pkg::ZERO16;
		end else if (ms_tick) begin
			ref_timer <= ref_timer + odt_pkg::ONE16;
		end
	end

	// step divider; restarts on a new selection, >= guards a shrinking length
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			unit_cnt_r <= odt_pkg::ZERO16;
			tbase_r <= odt_pkg::ODT_TB_1S;
			unit_tick <= 1'b0;
		end else begin
			tbase_r <= tbase;
			unit_tick <= 1'b0;
			if (tbase_r != tbase) begin
				unit_cnt_r <= odt_pkg::ZERO16;
			end else if (ms_tick) begin
				if (unit_cnt_r >= unit_last) begin
					unit_cnt_r <= odt_pkg::ZERO16;
					unit_tick <= 1'b1;
				end else begin
					unit_cnt_r <= unit_cnt_r + odt_pkg::ONE16;
				end
			end
		end
	end

endmodule : odt_timebase
`default_nettype wire

// ==== hw/odt_on_delay_up_timer.sv ====
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// on-delay count-up timer function block
//
// the trigger pin is synchronised, then latched into input memory on each
// end-of-scan pulse; the block is evaluated on each execution pulse using
// that latched value. count steps come from a free-running time base and are
// held pending until the next evaluation, so a step between scans is kept,
// but at most one step is taken per scan and further steps in it merge.

// Behaviour
// - trigger low: count zero, output low
// - trigger high: count steps up to preset
// - stopped: count frozen, output held high
// - output high iff count at least preset
// - preset spans full unsigned 16 bits
// - preset from constant or indexed data register
// - step length 1 s, 100/10/1 ms
// - raised preset: keep counting up to it
// - preset at or below count: stop, output now
// - runtime preset reverts on reset
// - unique instance index, 0-199 or 0-99
// - steps from free-running 16-bit reference timer; here a separate step divider on the ms prescaler makes them
// - trigger sampled at scan end, used next scan
module odt_on_delay_up_timer #(
	parameter int unsigned MS_CYCLES = odt_pkg::MS_CYCLES,
	parameter logic [15:0] PRESET_PROGRAMMED = odt_pkg::PRESET_DEFAULT,
	parameter logic [7:0] INSTANCE_INDEX = 8'h00,
	parameter bit SMALL_VARIANT = 1'b0
) (
	input wire logic core_clk, // system clock, 25 MHz
	input wire logic rst_b, // async reset, active low
	input wire logic trigger_input, // execution input from outside
	input wire logic scan_end, // end-of-scan pulse, samples trigger
	input wire logic scan_exec, // pulse: evaluate this block
	input wire logic [4:0] reg_addr, // register word address
	input wire logic [15:0] reg_wdata, // register write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	output logic [15:0] reg_rdata, // read data, cycle after strobe
	output logic timer_out, // timer output
	output logic [15:0] current_count // current value
);

	// ==========================================================================
	// declarations
	// trigger path: synchroniser pair and the scan's input memory
	logic trig_meta_r;
	logic trig_sync_r;
	logic trig_mem_r;

	// configuration, runtime preset and indirect preset storage
	odt_pkg::odt_cfg_t cfg_r;
	logic [15:0] preset_rt_r;
	logic [15:0] dreg_r [odt_pkg::DREG_NUM];
	logic [15:0] preset_eff;

	// time base and the step held over until the next evaluation
	logic unit_tick;
	logic [15:0] ref_timer;
	logic unit_pend_r;

	// evaluation state, count and output
	odt_pkg::odt_state_t state_r;
	odt_pkg::odt_state_t state_nxt;
	logic [15:0] count_r;
	logic [15:0] count_nxt;
	logic out_r;
	logic out_nxt;
	logic [15:0] count_inc;

	// identity flag and read path
	logic index_ok;
	logic [15:0] rdata_nxt;

	// true when the address falls in the data register window
	function automatic logic is_dreg(input logic [4:0] a);
		return (a >= odt_pkg::ADDR_DREG_BASE);
	endfunction : is_dreg

	// slot of the data register window that an address selects
	function automatic logic [3:0] dreg_slot(input logic [4:0] a);
		logic [4:0] d;
		d = a - odt_pkg::ADDR_DREG_BASE;
		return d[3:0];
	endfunction : dreg_slot

	// ==========================================================================
	// instance identity
	// uniqueness across instances is the integrator's duty; the block only
	// flags an index outside the range of the variant it sits in
	assign index_ok = SMALL_VARIANT ? (INSTANCE_INDEX <= odt_pkg::INDEX_MAX_SMALL)
		: (INSTANCE_INDEX <= odt_pkg::INDEX_MAX_FULL);

	// ==========================================================================
	// trigger path
	// two flops against metastability; the first is read by nothing else
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			trig_meta_r <= 1'b0;
			trig_sync_r <= 1'b0;
		end else begin
			trig_meta_r <= trigger_input;
			trig_sync_r <= trig_meta_r;
		end
	end

	// input memory: only updated at end of scan, so one scan sees one value;
	// pin to memory takes three edges at least, so a trigger pulse shorter
	// than one scan may never be seen by the timer at all
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			trig_mem_r <= 1'b0;
		end else if (scan_end) begin
			trig_mem_r <= trig_sync_r;
		end
	end

	// ==========================================================================
	// configuration registers
	// a new time base restarts the step divider, so a step already under way
	// is dropped; change the base only while the trigger is low
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cfg_r <= odt_pkg::CFG_RST;
		end else if (reg_wr) begin
			if (reg_addr == odt_pkg::ADDR_CTRL) begin
				cfg_r.src_dreg <= reg_wdata[odt_pkg::CTRL_SRC_BIT];
				cfg_r.tbase <= odt_pkg::odt_tbase_t'(reg_wdata[odt_pkg::CTRL_TB_MSB:odt_pkg::CTRL_TB_LSB]);
			end else if (reg_addr == odt_pkg::ADDR_DREG_IDX) begin
				cfg_r.dreg_idx <= reg_wdata[odt_pkg::DREG_IDX_W-1:0];
			end
		end
	end

	// runtime preset lives in flops only; reset brings back the programmed value
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			preset_rt_r <= PRESET_PROGRAMMED;
		end else if (reg_wr && (reg_addr == odt_pkg::ADDR_PRESET)) begin
			preset_rt_r <= reg_wdata;
		end
	end

	// data registers, software-owned storage for the indirect preset;
	// one flop group per slot, each decoding its own write
	for (genvar g = 0; g < odt_pkg::DREG_NUM; g++) begin : g_dreg
		localparam int unsigned SLOT = g;
		always_ff @(posedge core_clk or negedge rst_b) begin
			if (!rst_b) begin
				dreg_r[g] <= odt_pkg::ZERO16;
			end else if (reg_wr && is_dreg(reg_addr) && (dreg_slot(reg_addr) == SLOT[odt_pkg::DREG_IDX_W-1:0])) begin
				dreg_r[g] <= reg_wdata;
			end
		end
	end

	// preset actually compared, picked every cycle so a change acts next scan
	assign preset_eff = cfg_r.src_dreg ? dreg_r[cfg_r.dreg_idx] : preset_rt_r;

	// ==========================================================================
	// time base
	odt_timebase #(
		.MS_CYCLES(MS_CYCLES)
	) u_timebase (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.tbase(cfg_r.tbase),
		.unit_tick(unit_tick),
		.ref_timer(ref_timer)
	);

	// pending step: a tick in the same cycle as an evaluation is kept, not lost;
	// the free-running base means the first step may come up to one unit early;
	// every evaluation clears it, so a step seen while the trigger is low
	// is gone by the time counting starts, unless it lands in that same scan
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			unit_pend_r <= 1'b0;
		end else if (unit_tick) begin
			unit_pend_r <= 1'b1;
		end else if (scan_exec) begin
			unit_pend_r <= 1'b0;
		end
	end

	// ==========================================================================
	// timer evaluation
	// one evaluation per scan_exec pulse, at most one step each:
	//   idle  - trigger memory low, count and output cleared
	//   count - a pending step adds one until the preset is reached
	//   done  - count frozen and output high while the preset covers it
	// a preset change acts at the next evaluation, in either direction,
	// because the comparison with the preset is made afresh every time;
	// between evaluations nothing moves, so the output lags a preset
	// change by up to one scan
	// saturating increment guards against wrap even with a maximum preset
	assign count_inc = (count_r == 16'hffff) ? count_r : count_r + odt_pkg::ONE16;

	always_comb begin
		state_nxt = state_r;
		count_nxt = count_r;
		out_nxt = out_r;
		if (scan_exec) begin
			if (!trig_mem_r) begin
				state_nxt = odt_pkg::ODT_ST_IDLE;
				count_nxt = odt_pkg::ZERO16;
				out_nxt = 1'b0;
			end else begin
				case (state_r)
					odt_pkg::ODT_ST_IDLE, odt_pkg::ODT_ST_COUNT: begin
						if (count_r >= preset_eff) begin
							// preset lowered to or below count, or zero preset
							state_nxt = odt_pkg::ODT_ST_DONE;
							out_nxt = 1'b1;
						end else if (unit_pend_r) begin
							count_nxt = count_inc;
							if (count_inc >= preset_eff) begin
								state_nxt = odt_pkg::ODT_ST_DONE;
								out_nxt = 1'b1;
							end else begin
								state_nxt = odt_pkg::ODT_ST_COUNT;
								out_nxt = 1'b0;
							end
						end else begin
							state_nxt = odt_pkg::ODT_ST_COUNT;
							out_nxt = 1'b0;
						end
					end
					odt_pkg::ODT_ST_DONE: begin
						// frozen; a preset raised above the count resumes counting
						// in this very evaluation, so a pending step is not lost,
						// since the output must follow count versus preset
						if (count_r >= preset_eff) begin
							out_nxt = 1'b1;
						end else if (unit_pend_r) begin
							count_nxt = count_inc;
							if (count_inc >= preset_eff) begin
								out_nxt = 1'b1;
							end else begin
								state_nxt = odt_pkg::ODT_ST_COUNT;
								out_nxt = 1'b0;
							end
						end else begin
							state_nxt = odt_pkg::ODT_ST_COUNT;
							out_nxt = 1'b0;
						end
					end
					default: begin
						state_nxt = odt_pkg::ODT_ST_IDLE;
						count_nxt = odt_pkg::ZERO16;
						out_nxt = 1'b0;
					end
				endcase
			end
		end
	end

	// state register; it only moves on scan_exec, since the next-state
	// logic holds it otherwise
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= odt_pkg::ODT_ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// count register; current_count comes straight from here
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			count_r <= odt_pkg::ZERO16;
		end else begin
			count_r <= count_nxt;
		end
	end

	// output register; timer_out comes straight from here
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			out_r <= 1'b0;
		end else begin
			out_r <= out_nxt;
		end
	end

	// ports are the flops themselves, no logic after them
	assign timer_out = out_r;
	assign current_count = count_r;

	// ==========================================================================
	// register read path
	// map: control, runtime preset, data register index, status, count,
	// instance index, reference timer, then sixteen data registers; holes
	// read as zero so software can probe the map safely
	always_comb begin
		rdata_nxt = odt_pkg::ZERO16;
		if (reg_addr == odt_pkg::ADDR_CTRL) begin
			rdata_nxt[odt_pkg::CTRL_SRC_BIT] = cfg_r.src_dreg;
			rdata_nxt[odt_pkg::CTRL_TB_MSB:odt_pkg::CTRL_TB_LSB] = cfg_r.tbase;
		end else if (reg_addr == odt_pkg::ADDR_PRESET) begin
			rdata_nxt = preset_rt_r;
		end else if (reg_addr == odt_pkg::ADDR_DREG_IDX) begin
			rdata_nxt[odt_pkg::DREG_IDX_W-1:0] = cfg_r.dreg_idx;
		end else if (reg_addr == odt_pkg::ADDR_STATUS) begin
			rdata_nxt[odt_pkg::STAT_OUT_BIT] = out_r;
			rdata_nxt[odt_pkg::STAT_TRIG_BIT] = trig_mem_r;
			rdata_nxt[odt_pkg::STAT_RUN_BIT] = (state_r == odt_pkg::ODT_ST_COUNT);
			rdata_nxt[odt_pkg::STAT_IDX_OK_BIT] = index_ok;
		end else if (reg_addr == odt_pkg::ADDR_COUNT) begin
			rdata_nxt = count_r;
		end else if (reg_addr == odt_pkg::ADDR_INST) begin
			rdata_nxt[7:0] = INSTANCE_INDEX;
		end else if (reg_addr == odt_pkg::ADDR_REF) begin
			rdata_nxt = ref_timer;
		end else if (is_dreg(reg_addr)) begin
			rdata_nxt = dreg_r[dreg_slot(reg_addr)];
		end
	end

	// read data stand for one cycle only, zero otherwise
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= odt_pkg::ZERO16;
		end else if (reg_rd) begin
			reg_rdata <= rdata_nxt;
		end else begin
			reg_rdata <= odt_pkg::ZERO16;
		end
	end

endmodule : odt_on_delay_up_timer
`default_nettype wire

// ==== testbench/odt_scan_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// scan sequencer standing in for the rest of the user program
module odt_scan_model #(
	parameter int SCAN_LEN = 8
) (
	input wire logic core_clk, // system clock
	input wire logic rst_b, // async reset, active low
	input wire logic trig_req, // level the program wants on the trigger
	output logic trigger_input, // trigger to the timer
	output logic scan_end, // end-of-scan pulse
	output logic scan_exec // evaluate pulse
);
	int ph;
	// trigger only moves early in a scan, so it is settled well before the scan end
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ph <= 0;
			scan_end <= 1'b0;
			scan_exec <= 1'b0;
			trigger_input <= 1'b0;
		end else begin
			ph <= (ph == SCAN_LEN - 1) ? 0 : ph + 1;
			scan_end <= (ph == SCAN_LEN - 2);
			scan_exec <= (ph == 0);
			if (ph == 2)
				trigger_input <= trig_req;
		end
	end
endmodule : odt_scan_model
`default_nettype wire

// ==== testbench/odt_timer_props.sv ====
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// port-level checks of the timer block
module odt_timer_props (
	input wire logic core_clk, // system clock
	input wire logic rst_b, // async reset, active low
	input wire logic trigger_input, // trigger pin
	input wire logic scan_end, // end-of-scan pulse
	input wire logic scan_exec, // evaluate pulse
	input wire logic [4:0] reg_addr, // register address
	input wire logic reg_rd, // read strobe
	input wire logic [15:0] reg_rdata, // read data
	input wire logic timer_out, // timer output
	input wire logic [15:0] current_count // current value
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);

	// outputs move only as the result of an evaluation
	AST_HOLD: assert property (!scan_exec |=> $stable(timer_out) && $stable(current_count))
		else $error("outputs moved without evaluation");
	AST_STEP: assert property (scan_exec |=> current_count <= $past(current_count) + 17'h1)
		else $error("count jumped by more than one");
	// a falling count can only mean a clear
	AST_DROP: assert property (current_count < $past(current_count) |-> current_count == 16'h0 && !timer_out)
		else $error("count fell but not to zero");
	AST_FROZEN: assert property (timer_out && $past(timer_out) |-> current_count == $past(current_count))
		else $error("count moved while output high");
	AST_RISE: assert property ($rose(timer_out) |-> $past(scan_exec))
		else $error("output rose outside evaluation");
	AST_TRIG_LOW: assert property ((!trigger_input)[*4] ##0 scan_end ##2 scan_exec |=> current_count == 16'h0 && !timer_out)
		else $error("low trigger did not clear");
	AST_RD_COUNT: assert property (reg_rd && reg_addr == odt_pkg::ADDR_COUNT |=> reg_rdata == $past(current_count))
		else $error("count read differs from port");
	AST_RD_STATUS: assert property (reg_rd && reg_addr == odt_pkg::ADDR_STATUS |=> reg_rdata[0] == $past(timer_out))
		else $error("status output bit differs");
	AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 16'h0)
		else $error("read data outside read cycle");
endmodule : odt_timer_props

bind odt_on_delay_up_timer odt_timer_props u_odt_timer_props (.core_clk(core_clk), .rst_b(rst_b),
	.trigger_input(trigger_input), .scan_end(scan_end), .scan_exec(scan_exec), .reg_addr(reg_addr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_out(timer_out), .current_count(current_count));
`default_nettype wire

// ==== testbench/odt_on_delay_up_timer_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// self-checking bench with a scan-level reference model
module odt_on_delay_up_timer_tb;
	localparam int MSC = 4;
	logic core_clk, rst_b, trig_req, trigger_input, scan_end, scan_exec, reg_wr, reg_rd, timer_out;
	logic [4:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, current_count, v;
	int errors, num_checks, seed, i, exact, t1, t2, mem, cnt, pre, src, idx, p, out_m, ok_chk;
	int dreg[16];
	int unsigned ms[3];

	odt_on_delay_up_timer #(.MS_CYCLES(MSC), .INSTANCE_INDEX(8'hc7)) u_odt_on_delay_up_timer (
		.core_clk(core_clk), .rst_b(rst_b), .trigger_input(trigger_input), .scan_end(scan_end),
		.scan_exec(scan_exec), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .timer_out(timer_out), .current_count(current_count));
	odt_scan_model u_odt_scan_model (.core_clk(core_clk), .rst_b(rst_b), .trig_req(trig_req),
		.trigger_input(trigger_input), .scan_end(scan_end), .scan_exec(scan_exec));

	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	// reference model; evaluation sees the memory from before a same-edge scan end
	always @(posedge core_clk) begin
		ok_chk = 0;
		if (!rst_b) begin
			{t1, t2, mem, cnt, src, idx, out_m} = '0;
			pre = 10;
			dreg = '{default: 0};
		end else begin
			if (scan_exec) begin
				p = src ? dreg[idx] : pre;
				if (!mem) cnt = 0;
				else if (cnt < p) cnt++;
				out_m = mem && cnt >= p;
				ok_chk = 1;
			end
			if (scan_end) mem = t2;
			t2 = t1;
			t1 = trigger_input;
			if (reg_wr) begin
				if (reg_addr == odt_pkg::ADDR_CTRL) src = reg_wdata[0];
				else if (reg_addr == odt_pkg::ADDR_PRESET) pre = reg_wdata;
				else if (reg_addr == odt_pkg::ADDR_DREG_IDX) idx = reg_wdata[3:0];
				else if (reg_addr >= odt_pkg::ADDR_DREG_BASE) dreg[reg_addr - odt_pkg::ADDR_DREG_BASE] = reg_wdata;
			end
		end
	end

	// every evaluation result is compared while step timing is exact
	always @(negedge core_clk) begin
		if (ok_chk && exact) begin
			chk("count", 16'(cnt), current_count);
			chk("output", 16'(out_m), 16'(timer_out));
		end
	end

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rc(input logic [4:0] a, input logic [15:0] e, input string nm);
		logic [15:0] d;
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
		chk(nm, e, d);
	endtask : rc

	task automatic scans(input int n);
		repeat (n * 8) @(posedge core_clk);
	endtask : scans

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : wrap_up

	// watchdog sized well above the longest step test
	initial begin
		repeat (60000) @(posedge core_clk);
		errors++;
		wrap_up();
	end

	initial begin
		{errors, num_checks, trig_req, reg_wr, reg_rd, reg_addr, reg_wdata, rst_b} = '0;
		seed = 32'hbb81;
		exact = 1;
		ms = '{odt_pkg::UNIT_1S_MS, odt_pkg::UNIT_100MS_MS, odt_pkg::UNIT_10MS_MS};
		repeat (8) @(posedge core_clk);
		rst_b <= 1'b1;
		rc(odt_pkg::ADDR_PRESET, odt_pkg::PRESET_DEFAULT, "preset");
		rc(odt_pkg::ADDR_CTRL, 16'h0000, "ctrl");
		rc(odt_pkg::ADDR_INST, 16'h00c7, "index");
		rc(odt_pkg::ADDR_STATUS, 16'h0008, "status");
		rc(5'h07, 16'h0000, "unmapped");
		wr(odt_pkg::ADDR_COUNT, 16'h1234);
		rc(odt_pkg::ADDR_COUNT, 16'h0000, "count ro");
		wr(odt_pkg::ADDR_CTRL, 16'h0006);
		$display("register test done");
		// random presets, then zero preset fires on first evaluation
		for (i = 0; i < 4; i++) begin
			v = (i == 3) ? 16'h0000 : 16'(($random(seed) & 7) + 2);
			wr(odt_pkg::ADDR_PRESET, v);
			trig_req <= 1'b1;
			scans(v + 4);
			rc(odt_pkg::ADDR_COUNT, v, "final count");
			trig_req <= 1'b0;
			scans(3);
		end
		$display("count test done");
		// preset lowered below the count, then raised again mid-run
		wr(odt_pkg::ADDR_PRESET, 16'd20);
		trig_req <= 1'b1;
		scans(6);
		wr(odt_pkg::ADDR_PRESET, 16'd2);
		scans(3);
		wr(odt_pkg::ADDR_PRESET, 16'd30);
		scans(3);
		rc(odt_pkg::ADDR_STATUS, 16'h000e, "status counting");
		scans(27);
		trig_req <= 1'b0;
		scans(3);
		// preset taken from an indexed data register
		wr(odt_pkg::ADDR_DREG_BASE + 5'h05, 16'h0004);
		wr(odt_pkg::ADDR_DREG_IDX, 16'h0005);
		wr(odt_pkg::ADDR_CTRL, 16'h0007);
		trig_req <= 1'b1;
		scans(8);
		wr(odt_pkg::ADDR_DREG_BASE + 5'h05, 16'h0006);
		scans(5);
		rc(odt_pkg::ADDR_COUNT, 16'h0006, "dreg count");
		rc(odt_pkg::ADDR_DREG_BASE + 5'h05, 16'h0006, "dreg readback");
		rc(odt_pkg::ADDR_DREG_IDX, 16'h0005, "dreg index");
		trig_req <= 1'b0;
		$display("preset change test done");
		// slower bases: scan timing blurs the first step, so only a band is checked
		exact = 0;
		for (i = 0; i < 3; i++) begin
			trig_req <= 1'b0;
			wr(odt_pkg::ADDR_CTRL, 16'(i << 1));
			wr(odt_pkg::ADDR_PRESET, 16'hffff);
			scans(3);
			trig_req <= 1'b1;
			repeat (MSC * ms[i] * 5) @(posedge core_clk);
			#1 chk("steps", 16'h0001, 16'(current_count >= 4 && current_count <= 6));
		end
		rc(odt_pkg::ADDR_PRESET, 16'hffff, "full preset");
		// runtime preset is lost on a reset in mid-run
		rst_b <= 1'b0;
		repeat (3) @(posedge core_clk);
		rst_b <= 1'b1;
		rc(odt_pkg::ADDR_PRESET, odt_pkg::PRESET_DEFAULT, "preset after reset");
		// four whole milliseconds have passed when the next read is sampled
		repeat (4 * MSC) @(posedge core_clk);
		rc(odt_pkg::ADDR_REF, 16'h0004, "ref timer");
		$display("time base test done");
		wrap_up();
	end
endmodule : odt_on_delay_up_timer_tb
`default_nettype wire
